// *** core/asc_pkg.sv ***
/*
  Package for the asynchronous static memory port controller: pin bundle,
  request carrier, state codes and timing counts.
  Assumes a 100 MHz system clock; all times are whole cycles of 10 ns.
*/
package asc_pkg;

  localparam int ADDR_W             = 15;
  localparam int DATA_W             = 8;
  localparam int CLK_PERIOD_NS      = 10;

  // times in ns for the slowest grade served (15 ns part)
  localparam int CYCLE_TIME_NS      = 15;
  localparam int WRITE_PULSE_MIN_NS = 9;
  localparam int DATA_SETUP_NS      = 7;
  localparam int WRITE_TO_FLOAT_NS  = 7;
  localparam int OUTPUT_REACT_NS    = 2;
  localparam int OUT_FLOAT_NS       = 7;

  // least times round up to whole cycles
  localparam int READ_CYCLES        =
    (CYCLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WRITE_PULSE_CYCLES =
    (WRITE_PULSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int FLOAT_CYCLES       =
    (WRITE_TO_FLOAT_NS + OUTPUT_REACT_NS + CLK_PERIOD_NS - 1)
    / CLK_PERIOD_NS;
  localparam int TURN_CYCLES        =
    (OUT_FLOAT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam logic [3:0] CNT_ONE    = 4'h1;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic              cs_n;
    logic              oe_n;
    logic              we_n;
  } asc_pins_type;

  typedef struct packed {
    logic              write;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } asc_req_type;

  typedef enum logic [4:0] {
    ST_IDLE  = 5'h01,
    ST_READ  = 5'h02,
    ST_WRITE = 5'h04,
    ST_HOLD  = 5'h08,
    ST_TURN  = 5'h10
  } asc_state_type;

endpackage : asc_pkg

// *** core/asc_timer.sv ***
/*
  Down-counter that paces each phase of a memory access.
  Assumes the loader gives a count of at least one cycle.
*/
module asc_timer #(
  parameter int CNT_W = 4
) (
  input  wire logic             i_sys_clk,
  input  wire logic             i_rst_n,
  input  wire logic             i_load,
  input  wire logic [CNT_W-1:0] i_count,
  output logic                  o_done
);

  logic [CNT_W-1:0] cnt_reg;

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      cnt_reg <= '0;
    end else if (i_load) begin
      cnt_reg <= i_count;
    end else if (cnt_reg != '0) begin
      cnt_reg <= cnt_reg - 1'b1;
    end
  end

  // done in the cycle the last counted cycle elapses
  assign o_done = (cnt_reg == {{(CNT_W-1){1'b0}}, 1'b1});

endmodule : asc_timer

// *** core/asc_ctrl.sv ***
/*
  Controller for a 32K x 8 asynchronous static memory: turns single
  read or write requests into chip-select, output-enable, write-enable,
  address and data-pin sequences. Assumes a 100 MHz clock, pins sampled
  synchronously, and an external pad that resolves the data wire.
*/
// Summary of operation
// - address changes only while write enable or select is high.
// - address is valid no later than select falls for a read.
// - write with output enable low needs pulse beyond float plus reactivation.
// - write with output enable high may use the minimum write pulse.
// - controller never drives data while the memory may still drive.
module asc_ctrl
  import asc_pkg::*;
#(
  parameter int CNT_W = 4
) (
  input  wire logic              i_sys_clk,
  input  wire logic              i_rst_n,
  input  wire logic              i_req_valid,
  input  wire asc_pkg::asc_req_type i_req,
  output logic                   o_req_ready,
  output logic                   o_rd_valid,
  output logic [asc_pkg::DATA_W-1:0] o_rd_data,
  output asc_pkg::asc_pins_type  o_pins,
  output logic [asc_pkg::DATA_W-1:0] o_dq_out,
  output logic [asc_pkg::DATA_W-1:0] o_dq_oe,
  input  wire logic [asc_pkg::DATA_W-1:0] i_dq_in
);
  import asc_pkg::*;

  // every phase count, plus one, must fit the timer or a phase wraps to
  // zero and the state machine waits for a done that never comes
  if (CNT_W < 2
      || (1 << CNT_W) <= READ_CYCLES + 1
      || (1 << CNT_W) <= WRITE_PULSE_CYCLES + 1
      || (1 << CNT_W) <= FLOAT_CYCLES + 1
      || (1 << CNT_W) <= TURN_CYCLES + 1) begin : g_cnt_w_bad
    $error("asc_ctrl: CNT_W too small for timing counts");
  end

  function automatic logic [CNT_W-1:0] cyc(input int n);
    cyc = (n < 1) ? CNT_W'(1) : CNT_W'(n);
  endfunction : cyc

  // a read closes in the cycle its strobe window runs out
  function automatic logic rd_closing(input asc_state_type st,
                                      input logic          done);
    rd_closing = (st == ST_READ) && done;
  endfunction : rd_closing

  asc_state_type    state_reg;
  asc_pins_type     pins_reg;
  logic [DATA_W-1:0] dq_out_reg;
  logic             dq_oe_reg;
  logic             ready_reg;
  logic             rd_valid_reg;
  logic [DATA_W-1:0] rd_data_reg;
  logic             tmr_load;
  logic [CNT_W-1:0] tmr_count;
  logic             tmr_done;
  logic             take;

  assign take = ready_reg && i_req_valid;

  // one shared timer paces every phase; only one phase runs at a time
  asc_timer #(.CNT_W(CNT_W)) u_timer (
    .i_sys_clk (i_sys_clk),
    .i_rst_n   (i_rst_n),
    .i_load    (tmr_load),
    .i_count   (tmr_count),
    .o_done    (tmr_done)
  );

  always_comb begin
    tmr_load  = 1'b0;
    tmr_count = cyc(1);
    // each phase loads its length as it starts; done ends it
    case (state_reg)
      ST_IDLE: begin
        if (take) begin
          tmr_load  = 1'b1;
          // oe stays high on writes, so minimum pulse suffices
          tmr_count = i_req.write ? cyc(WRITE_PULSE_CYCLES)
                                  : cyc(READ_CYCLES);
        end
      end
      ST_READ: begin
        if (tmr_done) begin
          tmr_load  = 1'b1;
          tmr_count = cyc(TURN_CYCLES);
        end
      end
      ST_WRITE: begin
        if (tmr_done) begin
          tmr_load  = 1'b1;
          tmr_count = cyc(1);
        end
      end
      ST_HOLD, ST_TURN: begin
        tmr_load = 1'b0;
      end
      default: begin
        tmr_load = 1'b0;
      end
    endcase
  end

  // one access at a time; no queue, so the requester holds until taken
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      state_reg <= ST_IDLE;
    end else begin
      case (state_reg)
        ST_IDLE:  if (take) state_reg <= i_req.write ? ST_WRITE : ST_READ;
        ST_READ:  if (tmr_done) state_reg <= ST_TURN;
        ST_WRITE: if (tmr_done) state_reg <= ST_HOLD;
        ST_HOLD:  if (tmr_done) state_reg <= ST_IDLE;
        ST_TURN:  if (tmr_done) state_reg <= ST_IDLE;
        default:  state_reg <= ST_IDLE;
      endcase
    end
  end

  // strobes and address; select high between accesses keeps standby
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      pins_reg <= '{addr: '0, cs_n: 1'b1, oe_n: 1'b1, we_n: 1'b1};
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (take) begin
            // address moves only while select is still high
            pins_reg.addr <= i_req.addr;
            pins_reg.cs_n <= 1'b0;
            // select and write strobe fall together: memory never drives
            pins_reg.we_n <= ~i_req.write;
            // oe held high on writes keeps the float allowance out of
            // the pulse, so a one-cycle strobe is always long enough
            pins_reg.oe_n <= i_req.write;
          end
        end
        ST_READ: begin
          if (tmr_done) begin
            pins_reg.cs_n <= 1'b1;
            pins_reg.oe_n <= 1'b1;
          end
        end
        ST_WRITE: begin
          if (tmr_done) begin
            // both rise together, closing the overlap
            pins_reg.we_n <= 1'b1;
            pins_reg.cs_n <= 1'b1;
          end
        end
        default: begin
          pins_reg.cs_n <= pins_reg.cs_n;
        end
      endcase
    end
  end

  // data pin drive: on from write start, off one cycle after strobes rise
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      dq_oe_reg  <= 1'b0;
      dq_out_reg <= '0;
    end else if (state_reg == ST_IDLE && take && i_req.write) begin
      // memory was deselected with oe high, so lines are already free
      dq_oe_reg  <= 1'b1;
      dq_out_reg <= i_req.wdata;
    end else if (state_reg == ST_HOLD && tmr_done) begin
      dq_oe_reg  <= 1'b0;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      rd_valid_reg <= 1'b0;
      rd_data_reg  <= '0;
    end else begin
      rd_valid_reg <= rd_closing(state_reg, tmr_done);
      if (rd_closing(state_reg, tmr_done)) begin
        rd_data_reg <= i_dq_in;
      end
    end
  end

  // ready drops on the take edge so one held request is never taken twice
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      ready_reg <= 1'b0;
    end else if (take) begin
      ready_reg <= 1'b0;
    end else begin
      ready_reg <= (state_reg == ST_IDLE)
                || ((state_reg == ST_HOLD || state_reg == ST_TURN)
                    && tmr_done);
    end
  end

  assign o_req_ready = ready_reg;
  assign o_rd_valid  = rd_valid_reg;
  assign o_rd_data   = rd_data_reg;
  assign o_pins      = pins_reg;
  assign o_dq_out    = dq_out_reg;
  assign o_dq_oe     = {DATA_W{dq_oe_reg}};

endmodule : asc_ctrl

// *** sim/asc_ctrl_assertions.sv ***
/*
  Checker for the memory port controller: pin sequencing and data turn.
  Assumes it is bound into asc_ctrl and sees one clock domain.
*/
module asc_ctrl_assertions
  import asc_pkg::*;
#(
  parameter int CNT_W = 4
) (
  input  wire logic                       i_sys_clk,
  input  wire logic                       i_rst_n,
  input  wire logic                       i_req_valid,
  input  wire asc_pkg::asc_req_type       i_req,
  input  wire logic                       o_req_ready,
  input  wire asc_pkg::asc_pins_type      o_pins,
  input  wire logic [asc_pkg::DATA_W-1:0] o_dq_out,
  input  wire logic [asc_pkg::DATA_W-1:0] o_dq_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);

  property p_addr_hold;
    !o_pins.cs_n && !o_pins.we_n |=> $stable(o_pins.addr);
  endproperty
  a_addr_hold: assert property (p_addr_hold)
    else $error("address moved inside write");

  property p_rd_start;
    i_req_valid && o_req_ready && !i_req.write |=> !o_pins.cs_n
      && !o_pins.oe_n && o_pins.we_n && o_pins.addr == $past(i_req.addr);
  endproperty
  a_rd_start: assert property (p_rd_start)
    else $error("read address or strobes wrong");

  property p_short_pulse;
    $fell(o_pins.we_n) |-> o_pins.oe_n && $fell(o_pins.cs_n) ##1 o_pins.we_n;
  endproperty
  a_short_pulse: assert property (p_short_pulse)
    else $error("write pulse shape wrong");

  property p_no_clash;
    o_dq_oe != 8'h00 |-> o_pins.oe_n && $past(o_pins.oe_n);
  endproperty
  a_no_clash: assert property (p_no_clash)
    else $error("driving while memory may drive");

  property p_data_hold;
    $rose(o_pins.we_n) |-> o_dq_oe == 8'hFF && $stable(o_dq_out);
  endproperty
  a_data_hold: assert property (p_data_hold)
    else $error("write data not held");

  property p_wr_start;
    i_req_valid && o_req_ready && i_req.write |=> !o_pins.we_n
      && o_dq_out == $past(i_req.wdata) && o_pins.addr == $past(i_req.addr);
  endproperty
  a_wr_start: assert property (p_wr_start)
    else $error("write start wrong");

  property p_release;
    $fell(o_pins.oe_n) |-> o_dq_oe == 8'h00;
  endproperty
  a_release: assert property (p_release)
    else $error("lines not released for read");
endmodule : asc_ctrl_assertions

bind asc_ctrl asc_ctrl_assertions #(.CNT_W(CNT_W)) i_chk (
  .i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_req_valid(i_req_valid),
  .i_req(i_req), .o_req_ready(o_req_ready), .o_pins(o_pins),
  .o_dq_out(o_dq_out), .o_dq_oe(o_dq_oe));

// *** sim/asc_mem_model.sv ***
/*
  Behavioural 32K x 8 asynchronous static memory.
  Assumes the bench resolves the shared data wire from both enables.
*/
module asc_mem_model
  import asc_pkg::*;
(
  input  wire asc_pkg::asc_pins_type      i_pins,
  input  wire logic [asc_pkg::DATA_W-1:0] i_dq,
  output logic [asc_pkg::DATA_W-1:0]      o_dq,
  output logic                            o_dq_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];
  // no clock: everything follows pin levels, as the real part does
  wire wr_n = i_pins.cs_n | i_pins.we_n;
  always @(posedge wr_n) mem[i_pins.addr] <= i_dq;
  assign o_dq_oe = !i_pins.cs_n && !i_pins.oe_n && i_pins.we_n;
  assign o_dq = mem[i_pins.addr];
endmodule : asc_mem_model

// *** sim/tb_asc_ctrl.sv ***
/*
  Bench for asc_ctrl driving a behavioural memory on its pins.
  Assumes 100 MHz clock and requests held until taken.
*/
module tb_asc_ctrl;
  timeunit 1ns;
  timeprecision 1ns;
  import asc_pkg::*;
  logic        i_sys_clk = 1'b0;
  logic        i_rst_n = 1'b0;
  logic        i_req_valid = 1'b0;
  asc_req_type i_req = '0;
  logic        o_req_ready, o_rd_valid, mem_oe;
  logic [7:0]  o_rd_data, o_dq_out, o_dq_oe, mem_dq, dq_w;
  logic [7:0]  dq_last = 8'h00;
  asc_pins_type o_pins;
  int          num_errors = 0, n_checks = 0, cycles = 0;

  asc_ctrl i_asc_ctrl (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n),
    .i_req_valid(i_req_valid), .i_req(i_req), .o_req_ready(o_req_ready),
    .o_rd_valid(o_rd_valid), .o_rd_data(o_rd_data), .o_pins(o_pins),
    .o_dq_out(o_dq_out), .o_dq_oe(o_dq_oe), .i_dq_in(dq_w));
  asc_mem_model i_asc_mem_model (.i_pins(o_pins), .i_dq(dq_w),
    .o_dq(mem_dq), .o_dq_oe(mem_oe));
  // a floating wire toggles so a stale byte never passes as read data
  assign dq_w = (o_dq_oe & o_dq_out)
              | (~o_dq_oe & (mem_oe ? mem_dq : ~dq_last));

  task automatic test_done();
    if (num_errors == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : test_done

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic access(input logic wr, input logic [14:0] a,
                        input logic [7:0] d);
    @(posedge i_sys_clk);
    #1;
    i_req = '{write: wr, addr: a, wdata: d};
    i_req_valid = 1'b1;
    do @(posedge i_sys_clk); while (o_req_ready !== 1'b1);
    #1;
    i_req_valid = 1'b0;
    chk({7'h00, o_req_ready}, 8'h00);
  endtask : access

  task automatic rd(input logic [14:0] a, input logic [7:0] exp);
    int n;
    n = 0;
    access(1'b0, a, 8'h00);
    while (o_rd_valid !== 1'b1 && n < 16) begin
      @(posedge i_sys_clk);
      #1;
      n++;
    end
    chk(8'(n), 8'(READ_CYCLES));
    chk(o_rd_data, exp);
  endtask : rd

  task automatic t_reset();
    chk({5'h00, o_pins.cs_n, o_pins.oe_n, o_pins.we_n}, 8'h07);
    chk(o_dq_oe, 8'h00);
  endtask : t_reset

  task automatic t_bounds();
    access(1'b1, 15'h0000, 8'hA5);
    access(1'b1, 15'h7FFF, 8'h5A);
    rd(15'h7FFF, 8'h5A);
    rd(15'h0000, 8'hA5);
  endtask : t_bounds

  task automatic t_overwrite();
    access(1'b1, 15'h1234, 8'hC3);
    access(1'b1, 15'h1234, 8'h3C);
    access(1'b1, 15'h4321, 8'h81);
    rd(15'h1234, 8'h3C);
    rd(15'h4321, 8'h81);
  endtask : t_overwrite

  task automatic t_standby();
    repeat (4) @(posedge i_sys_clk);
    #1;
    chk({7'h00, mem_oe}, 8'h00);
    chk({7'h00, o_pins.cs_n}, 8'h01);
  endtask : t_standby

  initial begin
    forever #5 i_sys_clk = ~i_sys_clk;
  end

  always @(posedge i_sys_clk) begin
    dq_last <= dq_w;
    cycles <= cycles + 1;
    if (i_rst_n) chk({7'h00, mem_oe & (|o_dq_oe)}, 8'h00);
    if (cycles == 2000) begin
      num_errors++;
      test_done();
    end
  end

  initial begin
    repeat (2) @(posedge i_sys_clk);
    #1;
    i_rst_n = 1'b1;
    t_reset();
    t_bounds();
    t_overwrite();
    t_standby();
    test_done();
  end
endmodule : tb_asc_ctrl
